// [eps_slave.sv]
// two-wire eeprom slave front end with ahb-lite control port
//
// Contract
// - serial clock edges alone time every shifted bit; device never makes that clock.
// - data line only pulled low or released, open drain.
// - write protect high blocks programming of upper half; reads still allowed.
// - write protect low allows reading and writing the whole array.
// - protected write: ack slave and word address, withhold data byte ack.
// - floating write protect counts as low, unprotected; code samples wp_i as is, nothing forces it low.
// - address selection field compared with select pins 2, 1, 0.
// - all three select pins exist; no bit chooses a page block.
// - data changes only while clock low; high-clock changes are start or stop.
// - start is data falling while clock high; bus ignored until start.
// - stop is data rising while clock high; ends current communication.
// - stop enters standby; during write execution a second stop is needed.
// - matching slave address after start is acknowledged by pulling data low.
// - once write-selected, every further byte acknowledged, except protected data.
// - read: send byte, release, sample ack; continue on ack, else await stop.
// - upper four address bits must equal the device-type identifier.
// - address bit zero: one reads, zero writes.
// - one page block of 256 bytes addressed by 8-bit word address.
// - after eight bits transmitter releases; receiver drives ack in ninth clock.
`timescale 1ns/1ns
module eps_slave
#(
	// device-type identifier; value is arbitrary
	parameter logic [3:0] dev_type_p = 4'h6
)
(
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	input  wire logic                     scl_i,
	input  wire logic                     sda_i,
	output logic                          sda_o,
	output logic                          sda_oe_o,
	input  wire logic                     wp_i,
	input  wire logic                     select_pin_0_i,
	input  wire logic                     select_pin_1_i,
	input  wire logic                     select_pin_2_i,
	output logic                          standby_o,
	output logic                          wr_stb_o,
	output logic [7:0]                    wr_addr_o,
	output logic [7:0]                    wr_data_o,
	input  wire eps_pkg::eps_ahb_req_type ahb_req_i,
	output eps_pkg::eps_ahb_rsp_type      ahb_rsp_o
);

	eps_pkg::eps_state_type s_ff;
	eps_pkg::eps_state_type nxt_s;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       addr_match;
	logic       protect_hit;
	logic       accept;
	logic [3:0] evt_set;
	logic [3:0] evt_clr;
	logic       stop_clr;
	logic [31:0] rd_mux;

	// edges of the synchronised lines
	always_comb
	begin
		scl_rise  = s_ff.scl_s & ~s_ff.scl_q;
		scl_fall  = ~s_ff.scl_s & s_ff.scl_q;
		start_det = s_ff.scl_s & s_ff.scl_q & s_ff.sda_q & ~s_ff.sda_s;
		stop_det  = s_ff.scl_s & s_ff.scl_q & ~s_ff.sda_q & s_ff.sda_s;
		addr_match = (s_ff.shift[7:4] == dev_type_p)
			&& (s_ff.shift[3:1] == s_ff.sel_s);
		// wp synchroniser resets low, then follows wp_i; an undriven pin is not forced low
		protect_hit = s_ff.wp_s & s_ff.waddr[eps_pkg::UPPER_HALF_BIT];
		accept = ahb_req_i.hsel & ahb_req_i.hready & (ahb_req_i.htrans == eps_pkg::HTRANS_NONSEQ);
	end

	// register read data
	always_comb
	begin
		rd_mux = 32'h00000000;
		unique case (s_ff.paddr)
			eps_pkg::REG_CTRL:
			begin
				rd_mux[eps_pkg::CTRL_ENABLE_BIT] = s_ff.enable;
				rd_mux[eps_pkg::CTRL_WBUSY_BIT]  = s_ff.wbusy;
			end
			eps_pkg::REG_STATUS:
			begin
				rd_mux[3:0] = s_ff.evt;
				rd_mux[eps_pkg::STAT_PEND_BIT]    = s_ff.stop_pend;
				rd_mux[eps_pkg::STAT_RW_BIT]      = s_ff.rw;
				rd_mux[eps_pkg::STAT_STANDBY_BIT] = s_ff.standby;
				rd_mux[eps_pkg::STAT_WP_BIT]      = s_ff.wp_s;
				rd_mux[eps_pkg::STAT_PHASE_LSB +: 6] = s_ff.phase;
			end
			eps_pkg::REG_RXDATA:
			begin
				rd_mux[7:0] = s_ff.rxdata;
				rd_mux[eps_pkg::RX_WADDR_LSB +: 8] = s_ff.waddr;
			end
			eps_pkg::REG_TXDATA:
			begin
				rd_mux[7:0] = s_ff.txdata;
			end
			default:
			begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	always_comb
	begin
		nxt_s   = s_ff;
		evt_set = 4'h0;
		evt_clr = 4'h0;
		stop_clr = 1'b0;
		nxt_s.wr_stb = 1'b0;

		// two-flop synchronisers for every pin
		nxt_s.scl_m = scl_i;
		nxt_s.scl_s = s_ff.scl_m;
		nxt_s.scl_q = s_ff.scl_s;
		nxt_s.sda_m = sda_i;
		nxt_s.sda_s = s_ff.sda_m;
		nxt_s.sda_q = s_ff.sda_s;
		nxt_s.wp_m  = wp_i;
		nxt_s.wp_s  = s_ff.wp_m;
		nxt_s.sel_m = {select_pin_2_i, select_pin_1_i, select_pin_0_i};
		nxt_s.sel_s = s_ff.sel_m;

		// only ever pull low
		nxt_s.sda_out = 1'b0;

		// disabled: line released and the bus ignored
		if (!s_ff.enable)
		begin
			nxt_s.phase  = eps_pkg::ST_IDLE;
			nxt_s.sda_oe = 1'b0;
		end
		else if (start_det)
		begin
			// a start, repeated or not, restarts address reception
			nxt_s.phase     = eps_pkg::ST_RX;
			nxt_s.cnt       = 4'h0;
			nxt_s.got_addr  = 1'b0;
			nxt_s.got_waddr = 1'b0;
			nxt_s.sda_oe    = 1'b0;
			nxt_s.standby   = 1'b0;
		end
		else if (stop_det)
		begin
			evt_set[eps_pkg::EVT_STOP_BIT] = 1'b1;
			nxt_s.phase  = eps_pkg::ST_IDLE;
			nxt_s.sda_oe = 1'b0;
			// the first stop while a write runs only marks itself pending
			if (s_ff.wbusy && !s_ff.stop_pend)
			begin
				nxt_s.stop_pend = 1'b1;
			end
			else
			begin
				nxt_s.stop_pend = 1'b0;
				nxt_s.standby   = 1'b1;
			end
		end
		else
		begin
			unique case (s_ff.phase)
				eps_pkg::ST_IDLE,
				eps_pkg::ST_WAIT:
				begin
					nxt_s.sda_oe = 1'b0;
				end
				eps_pkg::ST_RX:
				begin
					// bits taken on the rise, acted on at the fall while the clock is low
					if (scl_rise)
					begin
						nxt_s.shift = {s_ff.shift[6:0], s_ff.sda_s};
						nxt_s.cnt   = s_ff.cnt + 4'h1;
					end
					else if (scl_fall && (s_ff.cnt == eps_pkg::BYTE_BITS))
					begin
						nxt_s.cnt = 4'h0;
						if (!s_ff.got_addr)
						begin
							if (addr_match)
							begin
								nxt_s.got_addr = 1'b1;
								nxt_s.rw       = s_ff.shift[0];
								nxt_s.sda_oe   = 1'b1;
								nxt_s.phase    = eps_pkg::ST_ACK;
								evt_set[eps_pkg::EVT_SELECT_BIT] = 1'b1;
							end
							else
							begin
								nxt_s.phase = eps_pkg::ST_WAIT;
							end
						end
						else if (!s_ff.got_waddr)
						begin
							nxt_s.waddr     = s_ff.shift;
							nxt_s.got_waddr = 1'b1;
							nxt_s.sda_oe    = 1'b1;
							nxt_s.phase     = eps_pkg::ST_ACK;
						end
						else
						begin
							nxt_s.rxdata = s_ff.shift;
							evt_set[eps_pkg::EVT_DATA_BIT] = 1'b1;
							if (protect_hit)
							begin
								evt_set[eps_pkg::EVT_PROTECT_BIT] = 1'b1;
								nxt_s.phase = eps_pkg::ST_WAIT;
							end
							else
							begin
								nxt_s.wr_stb = 1'b1;
								nxt_s.sda_oe = 1'b1;
								nxt_s.phase  = eps_pkg::ST_ACK;
							end
						end
					end
				end
				eps_pkg::ST_ACK:
				begin
					// hold ack through the ninth clock, release on its fall
					if (scl_fall)
					begin
						nxt_s.cnt = 4'h0;
						if (s_ff.rw)
						begin
							nxt_s.shift  = s_ff.txdata;
							nxt_s.sda_oe = ~s_ff.txdata[7];
							nxt_s.phase  = eps_pkg::ST_TX;
						end
						else
						begin
							nxt_s.sda_oe = 1'b0;
							nxt_s.phase  = eps_pkg::ST_RX;
						end
					end
				end
				eps_pkg::ST_TX:
				begin
					// the next bit moves only after the clock has fallen
					if (scl_fall)
					begin
						if (s_ff.cnt == eps_pkg::TX_LAST)
						begin
							nxt_s.sda_oe = 1'b0;
							nxt_s.phase  = eps_pkg::ST_RACK;
						end
						else
						begin
							nxt_s.cnt    = s_ff.cnt + 4'h1;
							nxt_s.shift  = {s_ff.shift[6:0], 1'b0};
							nxt_s.sda_oe = ~s_ff.shift[6];
						end
					end
				end
				eps_pkg::ST_RACK:
				begin
					// the master's answer is taken on the ninth rise
					if (scl_rise)
					begin
						nxt_s.mast_ack = ~s_ff.sda_s;
					end
					else if (scl_fall)
					begin
						if (s_ff.mast_ack)
						begin
							nxt_s.cnt    = 4'h0;
							nxt_s.shift  = s_ff.txdata;
							nxt_s.sda_oe = ~s_ff.txdata[7];
							nxt_s.phase  = eps_pkg::ST_TX;
						end
						else
						begin
							nxt_s.phase = eps_pkg::ST_WAIT;
						end
					end
				end
				default:
				begin
					nxt_s.phase  = eps_pkg::ST_IDLE;
					nxt_s.sda_oe = 1'b0;
				end
			endcase
		end

		// ahb-lite slave: one wait state, then registered answer
		if (s_ff.pend)
		begin
			nxt_s.pend = 1'b0;
			nxt_s.rsp.hreadyout = 1'b1;
			nxt_s.rsp.hrdata = 32'h00000000;
			if (s_ff.pwrite)
			begin
				unique case (s_ff.paddr)
					eps_pkg::REG_CTRL:
					begin
						nxt_s.enable = ahb_req_i.hwdata[eps_pkg::CTRL_ENABLE_BIT];
						nxt_s.wbusy  = ahb_req_i.hwdata[eps_pkg::CTRL_WBUSY_BIT];
						stop_clr     = ~ahb_req_i.hwdata[eps_pkg::CTRL_WBUSY_BIT];
					end
					eps_pkg::REG_STATUS:
					begin
						evt_clr = ahb_req_i.hwdata[3:0];
					end
					eps_pkg::REG_TXDATA:
					begin
						nxt_s.txdata = ahb_req_i.hwdata[7:0];
					end
					default:
					begin
						nxt_s.txdata = s_ff.txdata;
					end
				endcase
			end
			else
			begin
				nxt_s.rsp.hrdata = rd_mux;
			end
		end
		// address phase taken; hreadyout drops for one cycle
		else if (accept)
		begin
			nxt_s.pend   = 1'b1;
			nxt_s.paddr  = ahb_req_i.haddr[7:0];
			nxt_s.pwrite = ahb_req_i.hwrite;
			nxt_s.rsp.hreadyout = 1'b0;
		end
		nxt_s.rsp.hresp = eps_pkg::HRESP_OKAY;

		// a stop landing with a software clear keeps its pending mark
		if (stop_clr && !stop_det)
		begin
			nxt_s.stop_pend = 1'b0;
		end

		// hardware set wins over a software clear in the same cycle
		nxt_s.evt = (s_ff.evt & ~evt_clr) | evt_set;
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_ff <= eps_pkg::STATE_RST;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	always_comb
	begin
		sda_o     = s_ff.sda_out;
		sda_oe_o  = s_ff.sda_oe;
		standby_o = s_ff.standby;
		wr_stb_o  = s_ff.wr_stb;
		wr_addr_o = s_ff.waddr;
		wr_data_o = s_ff.rxdata;
		ahb_rsp_o = s_ff.rsp;
	end

endmodule

// [eps_pkg.sv]
// constants, types and state record of the two-wire eeprom slave front end
package eps_pkg;

	// register byte offsets on the ahb-lite port
	localparam logic [7:0] REG_CTRL         = 8'h00;
	localparam logic [7:0] REG_STATUS       = 8'h04;
	localparam logic [7:0] REG_RXDATA       = 8'h08;
	localparam logic [7:0] REG_TXDATA       = 8'h0C;

	// control fields
	localparam int         CTRL_ENABLE_BIT  = 0;
	localparam int         CTRL_WBUSY_BIT   = 1;
	localparam logic       CTRL_ENABLE_RST  = 1'b1;
	localparam logic       CTRL_WBUSY_RST   = 1'b0;

	// status fields, and the word address field of the received-data register
	localparam int         EVT_SELECT_BIT   = 0;
	localparam int         EVT_DATA_BIT     = 1;
	localparam int         EVT_PROTECT_BIT  = 2;
	localparam int         EVT_STOP_BIT     = 3;
	localparam int         STAT_PEND_BIT    = 4;
	localparam int         STAT_RW_BIT      = 5;
	localparam int         STAT_STANDBY_BIT = 6;
	localparam int         STAT_WP_BIT      = 7;
	localparam int         STAT_PHASE_LSB   = 8;
	localparam int         RX_WADDR_LSB     = 8;

	// serial framing
	localparam logic [3:0] BYTE_BITS        = 4'h8;
	localparam logic [3:0] TX_LAST          = 4'h7;
	localparam int         UPPER_HALF_BIT   = 7;

	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
	localparam logic       HRESP_OKAY       = 1'b0;

	typedef enum logic [5:0]
	{
		ST_IDLE = 6'h01,
		ST_RX   = 6'h02,
		ST_ACK  = 6'h04,
		ST_TX   = 6'h08,
		ST_RACK = 6'h10,
		ST_WAIT = 6'h20
	} eps_phase_type;

	typedef struct packed
	{
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} eps_ahb_req_type;

	typedef struct packed
	{
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} eps_ahb_rsp_type;

	typedef struct packed
	{
		logic          scl_m;
		logic          scl_s;
		logic          scl_q;
		logic          sda_m;
		logic          sda_s;
		logic          sda_q;
		logic          wp_m;
		logic          wp_s;
		logic [2:0]    sel_m;
		logic [2:0]    sel_s;
		eps_phase_type phase;
		logic [3:0]    cnt;
		logic [7:0]    shift;
		logic          got_addr;
		logic          got_waddr;
		logic          rw;
		logic          mast_ack;
		logic [7:0]    waddr;
		logic [7:0]    rxdata;
		logic [7:0]    txdata;
		logic          enable;
		logic          wbusy;
		logic          stop_pend;
		logic          standby;
		logic [3:0]    evt;
		logic          sda_oe;
		logic          sda_out;
		logic          wr_stb;
		logic          pend;
		logic [7:0]    paddr;
		logic          pwrite;
		eps_ahb_rsp_type rsp;
	} eps_state_type;

	// idle bus lines reset high so no false start is seen after release
	localparam eps_state_type STATE_RST = '{
		scl_m: 1'b1, scl_s: 1'b1, scl_q: 1'b1,
		sda_m: 1'b1, sda_s: 1'b1, sda_q: 1'b1,
		phase: ST_IDLE,
		enable: CTRL_ENABLE_RST,
		wbusy: CTRL_WBUSY_RST,
		standby: 1'b1,
		rsp: '{hrdata: 32'h00000000, hreadyout: 1'b1, hresp: HRESP_OKAY},
		default: '0
	};

endpackage

// [eps_slave_sva.sv]
// assertion checker on the ports of the two-wire eeprom slave
`timescale 1ns/1ns
module eps_slave_sva
(
	input wire logic                     clk_i,
	input wire logic                     reset_i,
	input wire logic                     scl_i,
	input wire logic                     sda_i,
	input wire logic                     sda_o,
	input wire logic                     sda_oe_o,
	input wire logic                     wp_i,
	input wire logic                     standby_o,
	input wire logic                     wr_stb_o,
	input wire logic [7:0]               wr_addr_o,
	input wire eps_pkg::eps_ahb_req_type ahb_req_i,
	input wire eps_pkg::eps_ahb_rsp_type ahb_rsp_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	drain_only_a: assert property (sda_oe_o |-> !sda_o)
		else $error("data line driven high");
	oe_low_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data drive changed with clock high");
	quiet_standby_a: assert property (standby_o |-> !sda_oe_o)
		else $error("data driven in standby");
	stb_pulse_a: assert property (wr_stb_o |=> !wr_stb_o)
		else $error("write strobe longer than one cycle");
	protect_a: assert property (wr_stb_o |-> !(wp_i && wr_addr_o[7]))
		else $error("protected byte accepted");
	standby_entry_a: assert property ($rose(standby_o) |-> scl_i && sda_i)
		else $error("standby entered without stop");
	wake_start_a: assert property ($fell(standby_o) |-> scl_i && !sda_i)
		else $error("standby left without start");
	ahb_wait_a: assert property (ahb_req_i.hsel && ahb_req_i.htrans == eps_pkg::HTRANS_NONSEQ
		&& ahb_rsp_o.hreadyout |=> !ahb_rsp_o.hreadyout ##1 ahb_rsp_o.hreadyout)
		else $error("data phase length wrong");
	ahb_okay_a: assert property (ahb_rsp_o.hresp == eps_pkg::HRESP_OKAY)
		else $error("response not okay");

	cover property (wr_stb_o);
	cover property ($rose(sda_oe_o));
	cover property ($rose(standby_o));
endmodule

// [eps_master_model.sv]
// behavioural two-wire bus master that makes the serial clock
`timescale 1ns/1ns
module eps_master_model
(
	input  wire logic clk_i,
	input  wire logic sda_oe_i,
	output logic      scl_o,
	output logic      sda_o
);
	logic low_q = 1'b0;

	// pull-up: a released wire reads high
	assign sda_o = !(low_q || sda_oe_i);
	initial scl_o = 1'b1;

	// data set only while clock low, sampled mid high
	task automatic pulse(output logic s);
		#40 scl_o = 1'b1;
		#40 s = sda_o;
		#40 scl_o = 1'b0;
		#40;
	endtask

	task automatic start;
		// align to the falling clock edge so no line moves on a sampling edge
		@(negedge clk_i);
		low_q = 1'b0;
		#40 scl_o = 1'b1;
		#80 low_q = 1'b1;
		#160 scl_o = 1'b0;
		#40;
	endtask

	task automatic send(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			low_q = !v[i];
			pulse(ack);
		end
		low_q = 1'b0;
		pulse(ack);
	endtask

	task automatic recv(input logic ack_bit, output logic [7:0] v);
		logic s;
		low_q = 1'b0;
		for (int i = 7; i >= 0; i--)
			pulse(v[i]);
		low_q = ack_bit;
		pulse(s);
		low_q = 1'b0;
	endtask

	task automatic stop;
		scl_o = 1'b0;
		#40 low_q = 1'b1;
		#40 scl_o = 1'b1;
		#80 low_q = 1'b0;
		#80;
	endtask
endmodule

// [tb_top.sv]
// self-checking testbench of the two-wire eeprom slave
`timescale 1ns/1ns
module tb_top;
	localparam logic [3:0] DEV = 4'h5; // device-type code, value is arbitrary
	logic                     clk_i = 1'b0;
	logic                     reset_i = 1'b1;
	logic                     wp = 1'b0;
	logic [2:0]               sel = 3'h5;
	logic                     scl, sda, sda_oe, sda_o, standby, wr_stb, ack;
	logic [7:0]               wr_addr, wr_data, b;
	logic [31:0]              rd;
	logic [7:0]               bad [4] = '{8'h58, 8'h5E, 8'h52, 8'h4A};
	eps_pkg::eps_ahb_req_type m = '0;
	eps_pkg::eps_ahb_rsp_type rsp;
	wire eps_pkg::eps_ahb_req_type req = {m[71:33], rsp.hreadyout, m[31:0]};
	int                       miscompares = 0;
	int                       comparisons = 0;
	int                       stb_count = 0;

	always #10 clk_i = !clk_i;

	always @(posedge clk_i)
	begin
		if (wr_stb === 1'b1)
			stb_count++;
	end

	eps_master_model i_eps_master_model(.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
	eps_slave #(.dev_type_p(DEV)) i_eps_slave(.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .wp_i(wp), .select_pin_0_i(sel[0]), .select_pin_1_i(sel[1]),
		.select_pin_2_i(sel[2]), .standby_o(standby), .wr_stb_o(wr_stb), .wr_addr_o(wr_addr),
		.wr_data_o(wr_data), .ahb_req_i(req), .ahb_rsp_o(rsp));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		m.hsel <= 1'b1;
		m.haddr <= {24'h000000, a};
		m.htrans <= eps_pkg::HTRANS_NONSEQ;
		m.hwrite <= w;
		m.hsize <= 3'h2;
		do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
		m.htrans <= 2'h0;
		m.hwdata <= wd;
		do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
		rd = rsp.hrdata;
	endtask

	task automatic tx(input logic [7:0] v, input logic e);
		i_eps_master_model.send(v, ack);
		chk(ack, e);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		#500000;
		miscompares++;
		print_verdict;
	end

	initial
	begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		ahb(1'b0, eps_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b1, eps_pkg::REG_TXDATA, 32'hA5);
		ahb(1'b0, eps_pkg::REG_TXDATA, 32'h0);
		chk(rd, 32'hA5);
		ahb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		chk(standby, 1'b1);
		$display("test registers done");
		i_eps_master_model.start;
		tx({DEV, 3'h5, 1'b0}, 1'b0);
		tx(8'h9C, 1'b0);
		tx(8'h3C, 1'b0);
		chk(wr_addr, 8'h9C);
		chk(wr_data, 8'h3C);
		i_eps_master_model.stop;
		chk(standby, 1'b1);
		chk(stb_count, 32'h1);
		ahb(1'b0, eps_pkg::REG_RXDATA, 32'h0);
		chk(rd, 32'h00009C3C);
		ahb(1'b0, eps_pkg::REG_STATUS, 32'h0);
		chk(rd, 32'h0000014B);
		ahb(1'b1, eps_pkg::REG_STATUS, 32'h0000000F);
		ahb(1'b0, eps_pkg::REG_STATUS, 32'h0);
		chk(rd, 32'h00000140);
		$display("test write done");
		@(posedge clk_i) wp <= 1'b1;
		i_eps_master_model.start;
		tx({DEV, 3'h5, 1'b0}, 1'b0);
		tx(8'hC0, 1'b0);
		tx(8'h11, 1'b1);
		i_eps_master_model.stop;
		chk(wr_data, 8'h11);
		chk(stb_count, 32'h1);
		i_eps_master_model.start;
		tx({DEV, 3'h5, 1'b0}, 1'b0);
		tx(8'h05, 1'b0);
		tx(8'h77, 1'b0);
		i_eps_master_model.stop;
		chk(wr_data, 8'h77);
		chk(stb_count, 32'h2);
		@(posedge clk_i) wp <= 1'b0;
		$display("test protect done");
		for (int i = 0; i < 4; i++)
		begin
			i_eps_master_model.start;
			tx(bad[i], 1'b1);
			chk(sda_oe, 1'b0);
			i_eps_master_model.stop;
		end
		$display("test select done");
		@(posedge clk_i) sel <= 3'h2;
		i_eps_master_model.start;
		tx({DEV, 3'h2, 1'b0}, 1'b0);
		i_eps_master_model.stop;
		i_eps_master_model.start;
		tx({DEV, 3'h5, 1'b0}, 1'b1);
		chk(sda_oe, 1'b0);
		i_eps_master_model.stop;
		@(posedge clk_i) sel <= 3'h5;
		$display("test strap done");
		i_eps_master_model.start;
		tx({DEV, 3'h5, 1'b1}, 1'b0);
		i_eps_master_model.recv(1'b1, b);
		chk(b, 8'hA5);
		i_eps_master_model.recv(1'b0, b);
		chk(b, 8'hA5);
		chk(sda_oe, 1'b0);
		i_eps_master_model.stop;
		$display("test read done");
		ahb(1'b1, eps_pkg::REG_CTRL, 32'h3);
		i_eps_master_model.start;
		tx({DEV, 3'h5, 1'b0}, 1'b0);
		i_eps_master_model.stop;
		chk(standby, 1'b0);
		i_eps_master_model.stop;
		chk(standby, 1'b1);
		ahb(1'b1, eps_pkg::REG_CTRL, 32'h1);
		$display("test second stop done");
		ahb(1'b1, eps_pkg::REG_CTRL, 32'h0);
		i_eps_master_model.start;
		tx({DEV, 3'h5, 1'b0}, 1'b1);
		chk(sda_oe, 1'b0);
		i_eps_master_model.stop;
		chk(standby, 1'b1);
		ahb(1'b1, eps_pkg::REG_CTRL, 32'h1);
		$display("test disable done");
		print_verdict;
	end
endmodule

bind eps_slave eps_slave_sva i_eps_slave_sva(.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i), .standby_o(standby_o), .wr_stb_o(wr_stb_o),
	.wr_addr_o(wr_addr_o), .ahb_req_i(ahb_req_i), .ahb_rsp_o(ahb_rsp_o));
